// File: pkg/flash_seq_consts.vh
// Notes on behaviour
// [R1] Host keeps output enable high while write and chip enable are both low.
// [R2] After protect code, sector number sits on sector_select_lines at each write strobe.
// [R3] Unwritten bytes of a programmed sector become undefined.
// [R4] Device re-protects itself after each program cycle.
// [R5] Host writes all 256 bytes of the sector every program.
// [R6] Host starts each byte load within 150 us of the previous one.
// [R7] Device flips toggle bit on each read strobe while programming.
// [R8] Host detects completion only when toggle bit stops changing, any polarity.
// [R9] Host keeps the polling address constant across polling reads.
// [R10] Identification entry writes AA, then 55, then 90.
// [R11] Entry bytes go to 5555, 2AAA, 5555; then wait 20 ms before reading.
// [R12] In identification mode A0 low gives maker code, A0 high part code.
// [R13] Device leaves identification mode on power loss.
// [R14] Exit sequence returns the device to normal array reads.
// [R15] Command addresses use A14..A0 and data lines, in hex.
// [R16] Lockout sequence with upper selection permanently locks the upper boot block.
// [R17] In id mode 00002 and 7FFF2 report boot lock: FE open, FF locked.
// [R18] Chip erase is refused if either boot block is locked.
// [R19] Host starts nothing new until polling shows the program cycle ended.
// [R20] Device ignores non-matching command sequences and stays in its mode.
`ifndef FLASH_SEQ_CONSTS_VH
`define FLASH_SEQ_CONSTS_VH

// Command words
`define CMD_ADDR_A        19'h05555
`define CMD_ADDR_B        19'h02AAA
`define CMD_UNLOCK_1      8'hAA
`define CMD_UNLOCK_2      8'h55
`define CMD_PROTECT       8'hA0
`define CMD_ID_ENTER      8'h90
`define CMD_ID_EXIT       8'hF0
`define CMD_LOCKOUT       8'h80
`define CMD_LOCK_CONFIRM  8'h40
`define LOCK_UPPER_ADDR   19'h7FFFF
`define LOCK_UPPER_DATA   8'h00
`define ID_LOW_BOOT_ADDR  19'h00002
`define ID_UP_BOOT_ADDR   19'h7FFF2
`define SECTOR_BYTES      9'h100

// Timing, figures in their own units, counts at 125 MHz
`define CLK_NS            8
`define STROBE_NS         200
`define STROBE_CYC        ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)
`define ACCESS_NS         200
`define ACCESS_CYC        ((`ACCESS_NS + 50 + `CLK_NS - 1) / `CLK_NS)
`define BLC_US            150
`define BLC_CYC           ((`BLC_US * 1000) / `CLK_NS)
`define ID_WAIT_MS        20
`define ID_WAIT_CYC       ((`ID_WAIT_MS * 1000000) / `CLK_NS)

`endif

// File: rtl/sector_byte_buffer.v
`timescale 1ns/10ps
// 256 x 8 sector image; read data registered
module sector_byte_buffer
(
   // Clock
   input  wire       i_sys_clk,
   // Write side
   input  wire       i_wr_en,
   input  wire [7:0] i_wr_addr,
   input  wire [7:0] i_wr_data,
   // Read side
   input  wire [7:0] i_rd_addr,
   output reg  [7:0] o_rd_data
);

   reg [7:0] mem [0:255];

   always @(posedge i_sys_clk)
   begin
      if (i_wr_en)
         mem[i_wr_addr] <= i_wr_data;
      o_rd_data <= mem[i_rd_addr];
   end

endmodule // sector_byte_buffer

// File: rtl/sector_flash_program_and_id_sequencer.v
`timescale 1ns/10ps
`include "flash_seq_consts.vh"
module sector_flash_program_and_id_sequencer
#(
   parameter BLC_CYC     = `BLC_CYC,
   parameter ID_WAIT_CYC = `ID_WAIT_CYC
)
(
   // Clock and reset
   input  wire        i_sys_clk,
   input  wire        i_srst,
   // User command port
   input  wire [2:0]  i_cmd,
   input  wire        i_cmd_valid,
   input  wire [10:0] i_sector,
   input  wire [18:0] i_addr,
   output reg         o_busy,
   output reg         o_done,
   output reg  [7:0]  o_rdata,
   // Sector image fill
   input  wire        i_fill_en,
   input  wire [7:0]  i_fill_addr,
   input  wire [7:0]  i_fill_data,
   // Flash pins
   output reg         o_ce_n,
   output reg         o_oe_n,
   output reg         o_we_n,
   output reg  [18:0] o_flash_addr,
   output reg  [7:0]  o_dq_out,
   output reg         o_dq_oe_n,
   input  wire [7:0]  i_dq_in
);

   // Commands: 0 read, 1 program sector, 2 id enter, 3 id exit, 4 lock upper
   localparam C_READ = 3'h0, C_PROG = 3'h1, C_IDIN = 3'h2, C_IDOUT = 3'h3, C_LOCK = 3'h4;

   localparam S_IDLE  = 4'h0, S_WLOW = 4'h1, S_WHIGH = 4'h2, S_NEXT = 4'h3;
   localparam S_RLOW  = 4'h4, S_RDONE = 4'h5, S_POLL = 4'h6, S_PGAP = 4'h7;
   localparam S_WAIT  = 4'h8, S_FIN  = 4'h9, S_FETCH = 4'hA;

   //****************************************************************
   // Pin synchroniser
   //****************************************************************
   reg [7:0] dq_meta_q;
   reg [7:0] dq_sync_q;
   always @(posedge i_sys_clk)
   begin
      dq_meta_q <= i_dq_in;
      dq_sync_q <= dq_meta_q;
   end

   //****************************************************************
   // Command step table
   //****************************************************************
   // Unlock steps are shared; the third step word picks the command
   function [26:0] cmd_step;
      input [2:0] cmd;
      input [2:0] idx;
      begin
         case (idx)
            3'h0: cmd_step = {`CMD_ADDR_A, `CMD_UNLOCK_1}; // [R10] [R11] [R15]
            3'h1: cmd_step = {`CMD_ADDR_B, `CMD_UNLOCK_2};
            3'h2:
               case (cmd)
                  C_IDIN:  cmd_step = {`CMD_ADDR_A, `CMD_ID_ENTER};
                  C_IDOUT: cmd_step = {`CMD_ADDR_A, `CMD_ID_EXIT};
                  C_LOCK:  cmd_step = {`CMD_ADDR_A, `CMD_LOCKOUT};
                  default: cmd_step = {`CMD_ADDR_A, `CMD_PROTECT};
               endcase
            3'h3: cmd_step = {`CMD_ADDR_A, `CMD_UNLOCK_1};
            3'h4: cmd_step = {`CMD_ADDR_B, `CMD_UNLOCK_2};
            3'h5: cmd_step = {`CMD_ADDR_A, `CMD_LOCK_CONFIRM};
            default: cmd_step = {`LOCK_UPPER_ADDR, `LOCK_UPPER_DATA}; // [R16]
         endcase
      end
   endfunction

   function [2:0] cmd_len;
      input [2:0] cmd;
      begin
         cmd_len = (cmd == C_LOCK) ? 3'h7 : 3'h3;
      end
   endfunction

   //****************************************************************
   // Sequencer
   //****************************************************************
   reg [3:0]  state_q;
   reg [2:0]  cmd_q;
   reg [2:0]  step_q;
   reg [8:0]  byte_q;
   reg [10:0] sector_q;
   reg [18:0] addr_q;
   reg [31:0] cnt_q;
   reg [7:0]  last_dq_q;
   reg [1:0]  stable_q;
   reg        loading_q;
   wire [7:0] buf_rd;
   wire [26:0] step_w = cmd_step(cmd_q, step_q);

   sector_byte_buffer u_buf
   (
      .i_sys_clk (i_sys_clk),
      .i_wr_en   (i_fill_en & ~o_busy),
      .i_wr_addr (i_fill_addr),
      .i_wr_data (i_fill_data),
      .i_rd_addr (byte_q[7:0]),
      .o_rd_data (buf_rd)
   );

   always @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         state_q   <= S_IDLE;
         cmd_q     <= 3'h0;
         step_q    <= 3'h0;
         byte_q    <= 9'h000;
         sector_q  <= 11'h000;
         addr_q    <= 19'h00000;
         cnt_q     <= 32'h0;
         last_dq_q <= 8'h00;
         stable_q  <= 2'h0;
         loading_q <= 1'b0;
         o_busy    <= 1'b0;
         o_done    <= 1'b0;
         o_rdata   <= 8'h00;
         o_ce_n    <= 1'b1;
         o_oe_n    <= 1'b1;
         o_we_n    <= 1'b1;
         o_flash_addr <= 19'h00000;
         o_dq_out  <= 8'h00;
         o_dq_oe_n <= 1'b1;
      end
      else
      begin
         o_done <= 1'b0;
         case (state_q)
            S_IDLE:
               if (i_cmd_valid)
               begin
                  o_busy    <= 1'b1;
                  cmd_q     <= i_cmd;
                  sector_q  <= i_sector;
                  addr_q    <= i_addr;
                  step_q    <= 3'h0;
                  byte_q    <= 9'h000;
                  loading_q <= 1'b0;
                  cnt_q     <= 32'h0;
                  state_q   <= (i_cmd == C_READ) ? S_RLOW : S_WLOW;
               end
            S_WLOW:
            begin
               // Output enable stays high for every write strobe [R1]
               o_oe_n <= 1'b1;
               if (loading_q)
               begin
                  o_flash_addr <= {sector_q, byte_q[7:0]}; // [R2]
                  o_dq_out     <= buf_rd;
               end
               else
               begin
                  o_flash_addr <= step_w[26:8];
                  o_dq_out     <= step_w[7:0];
               end
               o_dq_oe_n <= 1'b0;
               o_ce_n    <= 1'b0;
               o_we_n    <= 1'b0;
               cnt_q     <= 32'h0;
               state_q   <= S_WHIGH;
            end
            S_WHIGH:
            begin
               cnt_q <= cnt_q + 32'h1;
               if (cnt_q == `STROBE_CYC)
               begin
                  o_we_n <= 1'b1;
                  o_ce_n <= 1'b1;
               end
               else if (cnt_q == 2 * `STROBE_CYC)
               begin
                  o_dq_oe_n <= 1'b1;
                  state_q   <= S_NEXT;
               end
            end
            S_NEXT:
               if (loading_q)
               begin
                  // Whole sector is loaded, well inside the byte spacing [R5] [R6]
                  if (byte_q == `SECTOR_BYTES - 9'h001)
                  begin
                     cnt_q    <= 32'h0;
                     stable_q <= 2'h0;
                     state_q  <= S_RLOW;
                  end
                  else
                  begin
                     byte_q  <= byte_q + 9'h001;
                     state_q <= S_FETCH;
                  end
               end
               else if (step_q == cmd_len(cmd_q) - 3'h1)
               begin
                  if (cmd_q == C_PROG)
                  begin
                     loading_q <= 1'b1;
                     state_q   <= S_FETCH;
                  end
                  else if (cmd_q == C_IDIN)
                  begin
                     cnt_q   <= 32'h0;
                     state_q <= S_WAIT; // [R11]
                  end
                  else
                     state_q <= S_FIN;
               end
               else
               begin
                  step_q  <= step_q + 3'h1;
                  state_q <= S_WLOW;
               end
            S_FETCH:
               state_q <= S_WLOW; // Buffer read data settles in this cycle
            S_RLOW:
            begin
               // Polling reads use the fixed last address [R9]
               o_flash_addr <= loading_q ? {sector_q, 8'hFF} : addr_q; // [R12]
               o_ce_n    <= 1'b0;
               o_oe_n    <= 1'b0;
               o_we_n    <= 1'b1;
               o_dq_oe_n <= 1'b1;
               cnt_q     <= cnt_q + 32'h1;
               if (cnt_q == `ACCESS_CYC)
                  state_q <= S_RDONE;
            end
            S_RDONE:
            begin
               o_ce_n <= 1'b1;
               o_oe_n <= 1'b1;
               cnt_q  <= 32'h0;
               if (loading_q)
                  state_q <= S_POLL;
               else
               begin
                  o_rdata <= dq_sync_q;
                  state_q <= S_FIN;
               end
            end
            S_POLL:
            begin
               last_dq_q <= dq_sync_q;
               // Done only when the toggle bit stops moving, any level [R8] [R7]
               if (stable_q != 2'h0 && dq_sync_q[6] == last_dq_q[6])
               begin
                  o_rdata <= dq_sync_q;
                  state_q <= S_FIN; // [R19] [R4]
               end
               else
               begin
                  stable_q <= 2'h1;
                  state_q  <= S_PGAP;
               end
            end
            S_PGAP:
            begin
               // High gap between polls meets the output enable pulse minimum
               cnt_q <= cnt_q + 32'h1;
               if (cnt_q == `STROBE_CYC)
               begin
                  cnt_q   <= 32'h0;
                  state_q <= S_RLOW;
               end
            end
            S_WAIT:
            begin
               cnt_q <= cnt_q + 32'h1;
               if (cnt_q == ID_WAIT_CYC - 1)
                  state_q <= S_FIN;
            end
            S_FIN:
            begin
               o_busy  <= 1'b0;
               o_done  <= 1'b1;
               state_q <= S_IDLE;
            end
            default:
               state_q <= S_IDLE;
         endcase
      end
   end

endmodule // sector_flash_program_and_id_sequencer

// File: verification/flash_device_model.sv
`timescale 1ns/10ps
module flash_device_model
#(
   parameter [7:0] MAKER_ID = 8'h3C, // Arbitrary value
   parameter [7:0] PART_ID  = 8'h5A, // Arbitrary value
   parameter       PROG_NS  = 5000
)
(
   input  wire        i_ce_n,
   input  wire        i_oe_n,
   input  wire        i_we_n,
   input  wire [18:0] i_addr,
   input  wire [7:0]  i_dq,
   output wire [7:0]  o_dq
);
   logic [7:0] mem [int];
   logic [7:0] pend [int];
   logic [7:0] rd_q = 8'h00;
   integer     st = 0;
   integer     loads = 0;
   bit         loading = 0, pre = 0, arm = 0, up_lock = 0, tog = 0;
   bit         id_mode = 0;
   time        end_t = 0;
   wire        wr = !i_ce_n && !i_we_n;
   wire        rd = !i_ce_n && !i_oe_n;
   // Released bus shows the inverse, so a stale byte is never mistaken for data
   assign o_dq = rd ? rd_q : ~rd_q;
   always @(negedge wr)
   begin
      if (loading)
      begin
         pend[i_addr[7:0]] = i_dq;
         loads = loads + 1;
         if (loads == 256)
         begin
            loading = 0;
            loads = 0;
            end_t = $time + PROG_NS;
            for (int k = 0; k < 256; k++)
               mem[{i_addr[18:8], k[7:0]}] = pend.exists(k) ? pend[k] : 8'hXX;
            pend.delete();
         end
      end
      else if (arm)
      begin
         up_lock = up_lock | (i_addr == 19'h7FFFF && i_dq == 8'h00);
         arm = 0;
      end
      else if (st < 2)
         st = (i_addr[14:0] == (st ? 15'h2AAA : 15'h5555) && i_dq == (st ? 8'h55 : 8'hAA))
            ? st + 1 : 0;
      else
      begin
         st = 0;
         if (i_addr[14:0] == 15'h5555)
            case (i_dq)
               8'hA0: loading = 1;
               8'h90: id_mode = 1;
               8'hF0: id_mode = 0;
               8'h80: pre = 1;
               8'h40: arm = pre;
               8'h10: if (pre && !up_lock) mem.delete();
               default: pre = 0;
            endcase
      end
   end
   // Data is chosen as the read opens, a step after the address has settled,
   // so the host sees this access's byte and not the previous one
   always @(posedge rd)
   begin
      #1;
      if ($time < end_t)
      begin
         tog = !tog;
         rd_q = {~rd_q[7], tog, 6'h00};
      end
      else if (id_mode)
         rd_q = i_addr == 19'h0 ? MAKER_ID : i_addr == 19'h1 ? PART_ID :
            (i_addr == 19'h7FFF2 && up_lock) ? 8'hFF : 8'hFE;
      else
         rd_q = mem.exists(i_addr) ? mem[i_addr] : 8'hFF;
   end
endmodule // flash_device_model

// File: verification/flash_seq_monitor.sv
`timescale 1ns/10ps
module flash_seq_monitor
#(
   parameter BLC_CYC     = 18750,
   parameter ID_WAIT_CYC = 50
)
(
   // Clock and reset
   input wire        i_sys_clk,
   input wire        i_srst,
   // Command port
   input wire [2:0]  i_cmd,
   input wire        i_cmd_valid,
   input wire [10:0] i_sector,
   input wire        o_busy,
   input wire        o_done,
   // Flash pins
   input wire        o_ce_n,
   input wire        o_oe_n,
   input wire        o_we_n,
   input wire [18:0] o_flash_addr,
   input wire [7:0]  o_dq_out,
   input wire        o_dq_oe_n
);
   reg  [2:0]  cmd_q;
   reg  [10:0] sec_q;
   reg  [8:0]  wcnt_q;
   reg  [31:0] gap_q;
   reg         we_q;
   wire        we_fall = we_q & ~o_we_n;
   wire        prog    = (cmd_q == 3'h1);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   // Gap counts cycles since the last write strobe fell
   always @(posedge i_sys_clk)
   begin
      we_q  <= o_we_n;
      gap_q <= (i_srst | we_fall) ? 32'h0 : gap_q + 32'h1;
      if (i_srst | (i_cmd_valid & ~o_busy))
      begin
         cmd_q  <= i_srst ? 3'h0 : i_cmd;
         sec_q  <= i_sector;
         wcnt_q <= 9'h0;
      end
      else if (we_fall)
         wcnt_q <= wcnt_q + 9'h1;
   end
   a_oe_high_write: assert property (!o_ce_n && !o_we_n |-> o_oe_n)
      else $error("output enable low during a write");
   a_sector_lines: assert property (we_fall && prog && wcnt_q >= 9'h3 |->
      o_flash_addr[18:8] == sec_q) else $error("sector lines wrong at a load");
   a_full_sector: assert property (o_done && prog |-> wcnt_q == 9'h103)
      else $error("program ended without 256 loads");
   a_load_spacing: assert property (we_fall && prog && wcnt_q >= 9'h4 |->
      gap_q < BLC_CYC) else $error("byte loads too far apart");
   a_poll_address: assert property ($fell(o_oe_n) && prog |->
      o_flash_addr == {sec_q, 8'hFF}) else $error("polling address moved");
   a_id_sequence: assert property (we_fall && cmd_q == 3'h2 |-> wcnt_q < 9'h3 &&
      o_dq_out == (wcnt_q == 9'h1 ? 8'h55 : (wcnt_q == 9'h0 ? 8'hAA : 8'h90)) &&
      o_flash_addr[14:0] == (wcnt_q == 9'h1 ? 15'h2AAA : 15'h5555))
      else $error("id entry bytes wrong");
   a_id_wait: assert property (o_done && cmd_q == 3'h2 |->
      wcnt_q == 9'h3 && gap_q >= ID_WAIT_CYC) else $error("id entry ended too soon");
   // The last load pulse is still low when the count reaches its end, so only
   // a fresh fall of the write strobe after that point is an error
   a_quiet_polling: assert property (prog && wcnt_q == 9'h103 && o_we_n |=> o_we_n)
      else $error("write issued while polling");
   a_data_driven: assert property (!o_we_n |-> !o_dq_oe_n)
      else $error("data lines not driven during a write strobe");
   a_done_idle: assert property (o_done |-> !o_busy)
      else $error("done pulse while still busy");
   c_prog: cover property (o_done && prog);
   c_id: cover property (o_done && cmd_q == 3'h2);
   c_lock: cover property (o_done && cmd_q == 3'h4);
endmodule // flash_seq_monitor
bind sector_flash_program_and_id_sequencer flash_seq_monitor
   #(.BLC_CYC(BLC_CYC), .ID_WAIT_CYC(ID_WAIT_CYC)) mon
   (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cmd(i_cmd), .i_cmd_valid(i_cmd_valid),
    .i_sector(i_sector), .o_busy(o_busy), .o_done(o_done), .o_ce_n(o_ce_n),
    .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_flash_addr(o_flash_addr), .o_dq_out(o_dq_out),
    .o_dq_oe_n(o_dq_oe_n));

// File: verification/sector_flash_program_and_id_sequencer_test.sv
`timescale 1ns/10ps
module sector_flash_program_and_id_sequencer_test;
   localparam [7:0] MAKER = 8'h3C; // Arbitrary value
   localparam [7:0] PART  = 8'h5A; // Arbitrary value
   reg         i_sys_clk = 1'b0;
   reg         i_srst = 1'b1;
   reg  [2:0]  i_cmd = 3'h0;
   reg         i_cmd_valid = 1'b0;
   reg  [10:0] i_sector = 11'h000;
   reg  [18:0] i_addr = 19'h00000;
   reg         i_fill_en = 1'b0;
   reg  [7:0]  i_fill_addr = 8'h00;
   reg  [7:0]  i_fill_data = 8'h00;
   wire        o_busy, o_done, o_ce_n, o_oe_n, o_we_n, o_dq_oe_n;
   wire [7:0]  o_rdata, o_dq_out, dev_dq;
   wire [18:0] o_flash_addr;
   wire [7:0]  dq_bus = o_dq_oe_n ? dev_dq : o_dq_out;
   integer     err_total = 0;
   integer     checks_done = 0;
   integer     dones = 0;
   always #4 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) if (o_done === 1'b1) dones = dones + 1;
   sector_flash_program_and_id_sequencer #(.ID_WAIT_CYC(50)) dut (
      .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_cmd(i_cmd), .i_cmd_valid(i_cmd_valid),
      .i_sector(i_sector), .i_addr(i_addr), .o_busy(o_busy), .o_done(o_done),
      .o_rdata(o_rdata), .i_fill_en(i_fill_en), .i_fill_addr(i_fill_addr),
      .i_fill_data(i_fill_data), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n),
      .o_flash_addr(o_flash_addr), .o_dq_out(o_dq_out), .o_dq_oe_n(o_dq_oe_n),
      .i_dq_in(dq_bus));
   flash_device_model #(.MAKER_ID(MAKER), .PART_ID(PART)) dev (.i_ce_n(o_ce_n),
      .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_addr(o_flash_addr), .i_dq(dq_bus), .o_dq(dev_dq));
   task report_and_stop;
      begin
         if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task check(input [7:0] got, input [7:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp)
         begin
            err_total = err_total + 1;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   task run(input [2:0] c, input [10:0] s, input [18:0] a, input spoil);
      integer n;
      begin
         @(negedge i_sys_clk);
         i_cmd = c;
         i_sector = s;
         i_addr = a;
         i_cmd_valid = 1'b1;
         @(negedge i_sys_clk);
         i_cmd_valid = 1'b0;
         if (spoil)
         begin
            // A request while busy must be dropped
            repeat (4) @(negedge i_sys_clk);
            i_cmd = 3'h0;
            i_cmd_valid = 1'b1;
            @(negedge i_sys_clk);
            i_cmd_valid = 1'b0;
         end
         n = 0;
         while (o_done !== 1'b1 && n < 40000)
         begin
            @(negedge i_sys_clk);
            n = n + 1;
         end
         if (o_done !== 1'b1)
         begin
            err_total = err_total + 1;
            $display("unexpected at %0t: no completion", $time);
            report_and_stop;
         end
      end
   endtask
   task rd(input [18:0] a, input [7:0] exp);
      begin
         run(3'h0, 11'h000, a, 1'b0);
         check(o_rdata, exp);
      end
   endtask
   task t_program(input [10:0] s, input [7:0] base);
      integer k, d0;
      begin
         for (k = 0; k < 256; k = k + 1)
         begin
            @(negedge i_sys_clk);
            i_fill_en = 1'b1;
            i_fill_addr = k[7:0];
            i_fill_data = k[7:0] ^ base;
         end
         @(negedge i_sys_clk);
         i_fill_en = 1'b0;
         d0 = dones;
         run(3'h1, s, 19'h00000, 1'b1);
         repeat (60) @(negedge i_sys_clk);
         check(8'(dones - d0), 8'h01);
         for (k = 0; k < 256; k = k + 85)
            rd({s, k[7:0]}, k[7:0] ^ base);
      end
   endtask
   task t_ident(input [7:0] arr0);
      begin
         run(3'h2, 11'h000, 19'h00000, 1'b0);
         rd(19'h00000, MAKER);
         rd(19'h00001, PART);
         rd(19'h00002, 8'hFE);
         rd(19'h7FFF2, 8'hFE);
         run(3'h3, 11'h000, 19'h00000, 1'b0);
         rd(19'h00000, arr0);
      end
   endtask
   task t_lockout;
      begin
         run(3'h4, 11'h000, 19'h00000, 1'b0);
         run(3'h2, 11'h000, 19'h00000, 1'b0);
         rd(19'h7FFF2, 8'hFF);
         rd(19'h00002, 8'hFE);
         run(3'h3, 11'h000, 19'h00000, 1'b0);
      end
   endtask
   initial
   begin
      repeat (12) @(negedge i_sys_clk);
      i_srst = 1'b0;
      t_program(11'h000, 8'hA5);
      t_ident(8'hA5);
      t_lockout;
      t_program(11'h5A3, 8'h3C);
      report_and_stop;
   end
endmodule // sector_flash_program_and_id_sequencer_test
